// [hdl/seq_pkg.sv]
// Constants, register map and state type of the stage sequencer
package seq_pkg;
	// Timing of the elapsed-time tick
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_SEC_NS = 100_000_000;
	localparam int TICK_SEC_CYC = TICK_SEC_NS / CLK_PERIOD_NS;
	localparam int SEC_PER_MIN = 60;
	localparam int TICK_MIN_CYC = TICK_SEC_CYC * SEC_PER_MIN;
	// Sizes
	localparam int NSTAGE = 16;
	localparam int DW = 16;
	localparam int AW = 6;
	// Register map
	localparam logic [AW-1:0] A_CTRL = 6'h00;
	localparam logic [AW-1:0] A_CYC = 6'h01;
	localparam logic [AW-1:0] A_STAT = 6'h02;
	localparam logic [AW-1:0] A_PASS = 6'h03;
	localparam logic [AW-1:0] A_ELAP = 6'h04;
	localparam logic [1:0] G_CTRL = 2'h0;
	localparam logic [1:0] G_FREQ = 2'h1;
	localparam logic [1:0] G_TIME = 2'h2;
	localparam logic [1:0] G_RAMP = 2'h3;
	// Control fields
	localparam int F_MODE = 0;
	localparam int F_MANUAL = 2;
	localparam int F_MEM = 3;
	localparam int F_SMODE = 4;
	localparam int F_UNIT = 6;
	localparam int F_SRC = 8;
	// Status fields
	localparam int S_STAGE = 0;
	localparam int S_RUN = 4;
	localparam int S_HOLD = 5;
	localparam int S_DONE = 6;
	localparam int S_PAUSE = 7;
	localparam int S_RESUME = 8;
	// Reset values
	localparam logic [DW-1:0] CTRL_RST = 16'h0000;
	localparam logic [DW-1:0] CYC_RST = 16'h0001;
	localparam logic [DW-1:0] FREQ_DEF [NSTAGE] = '{
		16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0,
		16'h09C4, 16'h0BB8, 16'h0FA0, 16'h1388,
		16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	// Encodings
	localparam logic [2:0] SRC_STAGE = 3'h6;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_HOLD = 2'h1;
	localparam logic [1:0] MODE_COUNT = 2'h2;
	localparam logic [1:0] MODE_LOOP = 2'h3;
	localparam logic [1:0] SM_FIRST = 2'h0;
	localparam logic [1:0] SM_FREQ = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_HOLD = 2'b11,
		ST_DONE = 2'b10
	} seq_state_t;
endpackage

// [hdl/sync2.sv]
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sync2 #(parameter int W = 1) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// [hdl/tenth_tick.sv]
// Tick generator at one tenth of the selected time unit
`timescale 1ns/1ps
module tenth_tick (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Control
	input wire logic clr,
	input wire logic en,
	input wire logic unit_min,
	input wire logic [31:0] sec_cyc,
	input wire logic [31:0] min_cyc,
	// Pulse
	output logic tick
);
	logic [31:0] cnt_r;
	logic [31:0] lim;

	assign lim = unit_min ? min_cyc : sec_cyc;

	// Held count across a pause keeps the partial tenth
	always_ff @(posedge sys_clk) begin
		if (!nrst || clr) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (en && cnt_r >= lim - 32'h0000_0001) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= en ? cnt_r + 32'h0000_0001 : cnt_r;
			tick <= 1'b0;
		end
	end
endmodule

// [hdl/stage_seq.sv]
// Programmable multi-stage speed sequencer with register port
`timescale 1ns/1ps
module stage_seq
	import seq_pkg::*;
#(
	parameter int TICK_SEC_P = TICK_SEC_CYC,
	parameter int TICK_MIN_P = TICK_MIN_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Register port
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DW-1:0] rdata,
	// Command pins, asynchronous
	input wire logic run_cmd,
	input wire logic fault,
	input wire logic pwr_fail,
	input wire logic term_run,
	input wire logic term_pause,
	input wire logic term_reset,
	input wire logic dir_inv,
	// From the ramp and drive core
	input wire logic [DW-1:0] freq_upper,
	input wire logic [DW-1:0] freq_act,
	// To the ramp and drive core
	output logic drive_run,
	output logic [DW-1:0] freq_abs,
	output logic dir_rev,
	output logic [1:0] ramp_sel,
	output logic preload,
	output logic [DW-1:0] preload_val
);
	logic [DW-1:0] ctrl_r;
	logic [DW-1:0] cyc_lim_r;
	logic [DW-1:0] freq_r [NSTAGE];
	logic [DW-1:0] time_r [NSTAGE];
	logic [1:0] ramp_r [NSTAGE];
	logic [6:0] pins_s;
	logic run_s, fault_s, pwr_s, trun_s, pause_s, treset_s, dinv_s;
	logic [1:0] mode, smode;
	logic manual, mem_en, unit_min, src_ok;
	logic run_ok, run_ok_q, start;
	seq_state_t state_r;
	logic [3:0] cur_r;
	logic [DW-1:0] elapsed_r;
	logic [DW-1:0] pass_r;
	logic resume_r;
	logic resume_freq_r;
	logic [DW-1:0] lat_freq_r;
	logic first_ok, next_ok;
	logic [3:0] first_idx, next_idx;
	logic tick;
	logic stage_end, pass_end, lim_zero, limit_hit;
	logic [16:0] elap_inc, pass_inc;
	logic [DW-1:0] fsel, fmag;
	logic signed [16:0] wd_s, up_s;
	logic [DW-1:0] wclamp;
	logic resume_ok;

	sync2 #(.W(7)) pin_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.d({dir_inv, term_reset, term_pause, term_run, pwr_fail, fault, run_cmd}),
		.q(pins_s)
	);
	assign {dinv_s, treset_s, pause_s, trun_s, pwr_s, fault_s, run_s} = pins_s;

	assign mode = ctrl_r[F_MODE +: 2];
	assign manual = ctrl_r[F_MANUAL];
	assign mem_en = ctrl_r[F_MEM];
	assign smode = ctrl_r[F_SMODE +: 2];
	assign unit_min = ctrl_r[F_UNIT];
	assign src_ok = ctrl_r[F_SRC +: 3] == SRC_STAGE;

	// Manual operation needs the run terminal on top of the run command
	assign run_ok = run_s && !fault_s && !pwr_s && src_ok && (!manual || trun_s);
	assign start = run_ok && !run_ok_q;
	assign lim_zero = mode == MODE_COUNT && cyc_lim_r == '0;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			run_ok_q <= 1'b0;
		end else begin
			run_ok_q <= run_ok;
		end
	end

	// Lowest non-empty stage overall and above the current one
	always_comb begin
		first_ok = 1'b0;
		first_idx = '0;
		next_ok = 1'b0;
		next_idx = '0;
		for (int i = NSTAGE - 1; i >= 0; i--) begin
			if (time_r[i] != '0) begin
				first_ok = 1'b1;
				first_idx = 4'(i);
				if (4'(i) > cur_r) begin
					next_ok = 1'b1;
					next_idx = 4'(i);
				end
			end
		end
	end

	tenth_tick tick_gen (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clr(state_r != ST_RUN || stage_end),
		.en(!pause_s),
		.unit_min(unit_min),
		.sec_cyc(32'(TICK_SEC_P)),
		.min_cyc(32'(TICK_MIN_P)),
		.tick(tick)
	);

	assign elap_inc = {1'b0, elapsed_r} + 17'h0_0001;
	assign pass_inc = {1'b0, pass_r} + 17'h0_0001;
	assign stage_end = state_r == ST_RUN && run_ok && tick && !pause_s
		&& elap_inc >= {1'b0, time_r[cur_r]};
	assign pass_end = stage_end && !next_ok;
	assign limit_hit = pass_inc >= {1'b0, cyc_lim_r};
	assign resume_ok = resume_r && time_r[cur_r] != '0;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
		end else if (treset_s || !src_ok) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start && first_ok && !lim_zero) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!run_ok) begin
						state_r <= ST_IDLE;
					end else if (pass_end) begin
						unique case (mode)
							MODE_SINGLE: state_r <= ST_DONE;
							MODE_HOLD: state_r <= ST_HOLD;
							MODE_COUNT: state_r <= limit_hit ? ST_DONE : ST_RUN;
							MODE_LOOP: state_r <= ST_RUN;
						endcase
					end
				end
				ST_HOLD: begin
					if (!run_ok) begin
						state_r <= ST_IDLE;
					end
				end
				ST_DONE: begin
					// Leaving only on a dropped command forces a fresh run edge
					if (!run_ok) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || treset_s) begin
			cur_r <= '0;
			elapsed_r <= '0;
			pass_r <= '0;
			resume_r <= 1'b0;
			resume_freq_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			if (start && first_ok && !lim_zero) begin
				resume_r <= 1'b0;
				if (!resume_ok) begin
					cur_r <= first_idx;
					elapsed_r <= '0;
					pass_r <= '0;
				end
			end
		end else if (state_r == ST_RUN) begin
			if (!run_ok) begin
				// Power loss follows the memory bit, other stops the start mode
				resume_r <= pwr_s ? mem_en : smode != SM_FIRST;
				resume_freq_r <= !pwr_s && smode == SM_FREQ;
			end else if (stage_end) begin
				elapsed_r <= '0;
				if (next_ok) begin
					cur_r <= next_idx;
				end else begin
					pass_r <= pass_inc[DW-1:0];
					if (mode == MODE_LOOP || mode == MODE_COUNT) begin
						cur_r <= first_idx;
					end
				end
			end else if (tick && !pause_s) begin
				elapsed_r <= elap_inc[DW-1:0];
			end
		end else begin
			resume_r <= 1'b0;
		end
	end

	// Actual frequency at the stop instant, replayed as the ramp start point
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			lat_freq_r <= '0;
			preload <= 1'b0;
			preload_val <= '0;
		end else begin
			if (state_r == ST_RUN && !run_ok) begin
				lat_freq_r <= freq_act;
			end
			preload <= state_r == ST_IDLE && start && first_ok && !lim_zero
				&& resume_ok && resume_freq_r;
			preload_val <= lat_freq_r;
		end
	end

	assign fsel = freq_r[cur_r];
	assign fmag = fsel[DW-1] ? DW'(-fsel) : fsel;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			drive_run <= 1'b0;
			freq_abs <= '0;
			dir_rev <= 1'b0;
			ramp_sel <= '0;
		end else if (state_r == ST_RUN || state_r == ST_HOLD) begin
			drive_run <= 1'b1;
			freq_abs <= fmag;
			dir_rev <= fsel[DW-1] ^ dinv_s;
			ramp_sel <= ramp_r[cur_r];
		end else begin
			drive_run <= 1'b0;
			freq_abs <= '0;
			dir_rev <= 1'b0;
			ramp_sel <= '0;
		end
	end

	assign wd_s = {wdata[DW-1], wdata};
	assign up_s = {2'b00, freq_upper[DW-2:0]};
	always_comb begin
		if (wd_s > up_s) begin
			wclamp = up_s[DW-1:0];
		end else if (wd_s < -up_s) begin
			wclamp = DW'(-up_s);
		end else begin
			wclamp = wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_r <= CTRL_RST;
			cyc_lim_r <= CYC_RST;
			for (int i = 0; i < NSTAGE; i++) begin
				freq_r[i] <= FREQ_DEF[i];
				time_r[i] <= '0;
				ramp_r[i] <= '0;
			end
		end else if (wr) begin
			unique case (addr[5:4])
				G_CTRL: begin
					if (addr == A_CTRL) begin
						ctrl_r <= wdata;
					end else if (addr == A_CYC) begin
						cyc_lim_r <= wdata;
					end
				end
				G_FREQ: freq_r[addr[3:0]] <= wclamp;
				G_TIME: time_r[addr[3:0]] <= wdata;
				G_RAMP: ramp_r[addr[3:0]] <= wdata[1:0];
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (rd) begin
			unique case (addr[5:4])
				G_CTRL: begin
					case (addr)
						A_CTRL: rdata <= ctrl_r;
						A_CYC: rdata <= cyc_lim_r;
						A_STAT: begin
							rdata <= '0;
							rdata[S_STAGE +: 4] <= cur_r;
							rdata[S_RUN] <= state_r == ST_RUN;
							rdata[S_HOLD] <= state_r == ST_HOLD;
							rdata[S_DONE] <= state_r == ST_DONE;
							rdata[S_PAUSE] <= pause_s;
							rdata[S_RESUME] <= resume_r;
						end
						A_PASS: rdata <= pass_r;
						A_ELAP: rdata <= elapsed_r;
						default: rdata <= '0;
					endcase
				end
				G_FREQ: rdata <= freq_r[addr[3:0]];
				G_TIME: rdata <= time_r[addr[3:0]];
				G_RAMP: rdata <= {14'h0000, ramp_r[addr[3:0]]};
			endcase
		end else begin
			rdata <= '0;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	zero_skip_a: assert property (
		state_r == ST_RUN |-> time_r[cur_r] != '0)
		else $error("running on a stage with zero time");
	single_stop_a: assert property (
		pass_end && mode == MODE_SINGLE && !treset_s && src_ok
		|=> state_r == ST_DONE ##1 !drive_run)
		else $error("single pass did not stop");
	hold_last_a: assert property (
		state_r == ST_HOLD && $past(state_r) == ST_HOLD |=> $stable(freq_abs))
		else $error("held frequency changed");
	count_limit_a: assert property (
		state_r == ST_RUN && mode == MODE_COUNT |-> pass_r < cyc_lim_r)
		else $error("pass count reached limit while running");
	zero_limit_a: assert property (
		state_r == ST_IDLE && lim_zero |=> state_r != ST_RUN)
		else $error("started with zero cycle limit");
	loop_restart_a: assert property (
		pass_end && mode == MODE_LOOP && !treset_s && src_ok
		|=> state_r == ST_RUN && cur_r == $past(first_idx))
		else $error("continuous mode did not restart");
	dir_sign_a: assert property (
		state_r == ST_RUN |=> dir_rev == ($past(fsel[DW-1]) ^ $past(dinv_s)))
		else $error("direction does not follow sign");
	ramp_pick_a: assert property (
		state_r == ST_RUN |=> ramp_sel == $past(ramp_r[cur_r]))
		else $error("ramp selector mismatch");
	src_gate_a: assert property (
		!src_ok ##1 !src_ok |=> !drive_run)
		else $error("drive runs with other frequency source");
	stage_time_a: assert property (
		state_r == ST_RUN && run_ok && !resume_r |-> elapsed_r < time_r[cur_r])
		else $error("elapsed time passed stage time");
endmodule

// [bench/drive_model.sv]
// Ramp and drive core model that slews the actual frequency
`timescale 1ns/1ps
module drive_model
	import seq_pkg::*;
#(
	parameter logic [DW-1:0] UPPER = 16'h1388
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// From the sequencer
	input wire logic drive_run,
	input wire logic [DW-1:0] freq_abs,
	input wire logic preload,
	input wire logic [DW-1:0] preload_val,
	// To the sequencer
	output logic [DW-1:0] freq_upper,
	output logic [DW-1:0] freq_act
);
	assign freq_upper = UPPER;
	// One step a cycle and decelerating when stopped, so a late latch reads low
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			freq_act <= 16'h0000;
		end else if (preload) begin
			freq_act <= preload_val;
		end else if (drive_run && freq_act < freq_abs) begin
			freq_act <= freq_act + 16'h0001;
		end else if (freq_act != 16'h0000 && (!drive_run || freq_act > freq_abs)) begin
			freq_act <= freq_act - 16'h0001;
		end
	end
endmodule

// [bench/multi_stage_speed_sequencer_bench.sv]
// Self-checking bench of the stage sequencer
`timescale 1ns/1ps
module multi_stage_speed_sequencer_bench
	import seq_pkg::*;
;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run_cmd = 1'b0;
	logic fault = 1'b0;
	logic pwr_fail = 1'b0;
	logic term_run = 1'b0;
	logic term_pause = 1'b0;
	logic term_reset = 1'b0;
	logic dir_inv = 1'b0;
	logic [DW-1:0] rdata, freq_upper, freq_act, freq_abs, preload_val, pre_val;
	logic drive_run, dir_rev, preload;
	logic pre_seen = 1'b0;
	logic [1:0] ramp_sel;
	int err_total = 0;
	int check_count = 0;

	stage_seq #(.TICK_SEC_P(10), .TICK_MIN_P(20)) uut (.sys_clk(sys_clk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .run_cmd(run_cmd),
		.fault(fault), .pwr_fail(pwr_fail), .term_run(term_run), .term_pause(term_pause),
		.term_reset(term_reset), .dir_inv(dir_inv), .freq_upper(freq_upper),
		.freq_act(freq_act), .drive_run(drive_run), .freq_abs(freq_abs), .dir_rev(dir_rev),
		.ramp_sel(ramp_sel), .preload(preload), .preload_val(preload_val));
	drive_model core (.sys_clk(sys_clk), .nrst(nrst), .drive_run(drive_run),
		.freq_abs(freq_abs), .preload(preload), .preload_val(preload_val),
		.freq_upper(freq_upper), .freq_act(freq_act));

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	// Cleared by reset here so that only this process drives the flag
	always @(posedge sys_clk) begin
		if (nrst === 1'b0) begin
			pre_seen <= 1'b0;
		end else if (preload === 1'b1) begin
			pre_seen <= 1'b1;
			pre_val <= preload_val;
		end
	end

	task automatic summarize;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wrr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk) wr <= 1'b0;
	endtask
	task automatic rdr(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk) rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wdr(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && drive_run !== v; i++) @(posedge sys_clk);
		chk(drive_run, v);
	endtask
	task automatic wfq(input logic [DW-1:0] v, input int lim);
		int i;
		for (i = 0; i < lim && freq_abs !== v; i++) @(posedge sys_clk);
		chk(freq_abs, v);
	endtask
	task automatic rst;
		@(posedge sys_clk);
		nrst <= 1'b0;
		{run_cmd, fault, pwr_fail, term_run, term_pause, term_reset, dir_inv} <= '0;
		wt(3);
		nrst <= 1'b1;
	endtask
	task automatic cfg(input logic [15:0] c, t0, t1, t2);
		rst();
		wrr(A_CTRL, c);
		wrr({G_TIME, 4'h0}, t0);
		wrr({G_TIME, 4'h1}, t1);
		wrr({G_TIME, 4'h2}, t2);
	endtask
	// Cycles spent on the first stage after the drive starts
	task automatic go(output int n);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wdr(1'b1, 10);
		n = 0;
		while (freq_abs === 16'h01F4 && n < 60) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	task automatic t_regs;
		logic [15:0] d;
		int i;
		rst();
		rdr(A_CTRL, d);
		chk(d, 16'h0000);
		rdr(A_CYC, d);
		chk(d, 16'h0001);
		for (i = 0; i < 16; i++) begin
			rdr({G_FREQ, i[3:0]}, d);
			chk(d, i < 6 ? 16'(500 * (i + 1)) : i == 6 ? 16'h0FA0 : i == 7 ? 16'h1388 : 16'h0);
			rdr({G_TIME, i[3:0]}, d);
			chk(d, 16'h0000);
			rdr({G_RAMP, i[3:0]}, d);
			chk(d, 16'h0000);
		end
		wrr(A_CYC, 16'hFFFF);
		rdr(A_CYC, d);
		chk(d, 16'hFFFF);
		wrr({G_TIME, 4'hF}, 16'hFFFF);
		rdr({G_TIME, 4'hF}, d);
		chk(d, 16'hFFFF);
		wrr({G_FREQ, 4'h3}, 16'hE000);
		rdr({G_FREQ, 4'h3}, d);
		chk(d, 16'hEC78);
		wrr(A_PASS, 16'h1234);
		rdr(A_PASS, d);
		chk(d, 16'h0000);
		rdr(6'h05, d);
		chk(d, 16'h0000);
	endtask
	task automatic t_single;
		logic [15:0] d;
		int n;
		cfg(16'h0600, 16'h0002, 16'h0000, 16'h0002);
		wrr({G_RAMP, 4'h2}, 16'h0003);
		go(n);
		chk(n >= 18 && n <= 22, 1'b1);
		chk(freq_abs, 16'h05DC);
		chk(ramp_sel, 2'd3);
		wdr(1'b0, 30);
		wt(20);
		chk(drive_run, 1'b0);
		rdr(A_STAT, d);
		chk(d[S_DONE], 1'b1);
		@(posedge sys_clk) run_cmd <= 1'b0;
		wt(5);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wdr(1'b1, 10);
		cfg(16'h0640, 16'h0002, 16'h0000, 16'h0000);
		go(n);
		chk(n >= 38 && n <= 42, 1'b1);
	endtask
	task automatic t_modes;
		logic [15:0] d;
		cfg(16'h0601, 16'h0001, 16'h0001, 16'h0000);
		wrr({G_FREQ, 4'h1}, 16'hFC18);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wt(60);
		chk(drive_run, 1'b1);
		chk(freq_abs, 16'h03E8);
		chk(dir_rev, 1'b1);
		@(posedge sys_clk) dir_inv <= 1'b1;
		wt(6);
		chk(dir_rev, 1'b0);
		cfg(16'h0602, 16'h0001, 16'h0001, 16'h0000);
		wrr(A_CYC, 16'h0002);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wdr(1'b1, 10);
		wdr(1'b0, 80);
		rdr(A_PASS, d);
		chk(d, 16'h0002);
		@(posedge sys_clk) run_cmd <= 1'b0;
		wrr(A_CYC, 16'h0000);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wt(20);
		chk(drive_run, 1'b0);
		cfg(16'h0603, 16'h0001, 16'h0001, 16'h0000);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wfq(16'h03E8, 40);
		wfq(16'h01F4, 30);
		wt(30);
		chk(drive_run, 1'b1);
		@(posedge sys_clk) run_cmd <= 1'b0;
		wdr(1'b0, 10);
	endtask
	// Stops in stage one by command, fault or power loss, then restarts
	task automatic t_resume(input logic [15:0] c, input int how, input logic [3:0] stg,
		input logic pre);
		logic [15:0] d, act;
		cfg(c, 16'h0001, 16'h0005, 16'h0000);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wfq(16'h03E8, 40);
		wt(10);
		@(posedge sys_clk);
		if (how == 0) run_cmd <= 1'b0;
		if (how == 1) fault <= 1'b1;
		if (how == 2) pwr_fail <= 1'b1;
		wdr(1'b0, 10);
		act = freq_act;
		wt(5);
		@(posedge sys_clk);
		run_cmd <= 1'b1;
		fault <= 1'b0;
		pwr_fail <= 1'b0;
		wdr(1'b1, 10);
		rdr(A_STAT, d);
		chk(d[3:0], stg);
		// One tenth had elapsed in stage one at the stop; a resume keeps it
		rdr(A_ELAP, d);
		chk(d, stg == 4'h1 ? 16'h0001 : 16'h0000);
		chk(pre_seen, pre);
		if (pre) chk(16'(pre_val - act + 16'h0004) <= 16'h0008, 1'b1);
	endtask
	task automatic t_manual;
		logic [15:0] d;
		cfg(16'h0604, 16'h0001, 16'h0001, 16'h0000);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wt(20);
		chk(drive_run, 1'b0);
		@(posedge sys_clk) term_run <= 1'b1;
		wdr(1'b1, 10);
		@(posedge sys_clk) term_pause <= 1'b1;
		wt(40);
		chk(freq_abs, 16'h01F4);
		@(posedge sys_clk) term_pause <= 1'b0;
		wfq(16'h03E8, 20);
		@(posedge sys_clk) term_reset <= 1'b1;
		wdr(1'b0, 10);
		rdr(A_STAT, d);
		chk(d[3:0], 4'h0);
		cfg(16'h0500, 16'h0001, 16'h0001, 16'h0000);
		@(posedge sys_clk) run_cmd <= 1'b1;
		wt(20);
		chk(drive_run, 1'b0);
	endtask

	initial begin
		t_regs();
		t_single();
		t_modes();
		t_resume(16'h0600, 0, 4'h0, 1'b0);
		t_resume(16'h0610, 1, 4'h1, 1'b0);
		t_resume(16'h0620, 0, 4'h1, 1'b1);
		t_resume(16'h0600, 2, 4'h0, 1'b0);
		t_resume(16'h0608, 2, 4'h1, 1'b0);
		t_manual();
		summarize();
	end
	// Whole run needs about 1000 cycles
	initial begin
		wt(20000);
		err_total++;
		summarize();
	end
endmodule
